/* hdl/sram_host_ctrl.sv */
`timescale 1ns/100ps
module sram_host_ctrl #(
  parameter bit WIDE_ORG = 1'b1,
  parameter int ADDR_W = WIDE_ORG ? sram_host_pkg::WIDE_ADDR_W : sram_host_pkg::NARROW_ADDR_W,
  parameter int DATA_W = WIDE_ORG ? sram_host_pkg::WIDE_DATA_W : sram_host_pkg::NARROW_DATA_W
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // user request port
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic o_ready,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  // memory control pins
  output logic o_latch_gate_n,
  output logic o_latched_select_n,
  output logic o_level_select_n,
  output logic o_write_enable_n,
  output logic [ADDR_W-1:0] o_addr,
  // shared data pins
  input wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0] o_dq,
  output logic o_dq_oe_n
);

  // ****************************************************************
  // cycle counts at the widths of the counter
  // ****************************************************************
  localparam logic [sram_host_pkg::CNT_W-1:0] SETUP_CNT =
    sram_host_pkg::CNT_W'(sram_host_pkg::ADDR_SETUP_CYC - 1);
  localparam logic [sram_host_pkg::CNT_W-1:0] READ_CNT =
    sram_host_pkg::CNT_W'(sram_host_pkg::READ_LOW_CYC - 1);
  localparam logic [sram_host_pkg::CNT_W-1:0] WRITE_CNT =
    sram_host_pkg::CNT_W'(sram_host_pkg::WRITE_LOW_CYC - 1);
  localparam logic [sram_host_pkg::CNT_W-1:0] HOLD_CNT =
    sram_host_pkg::CNT_W'(sram_host_pkg::DATA_HOLD_CYC - 1);
  localparam logic [sram_host_pkg::CNT_W-1:0] PRE_CNT =
    sram_host_pkg::CNT_W'(sram_host_pkg::PRECHARGE_CYC - 1);
  localparam logic [sram_host_pkg::CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [sram_host_pkg::CNT_W-1:0] CNT_ONE = sram_host_pkg::CNT_W'(1);

  sram_host_pkg::cycle_state_e state;
  sram_host_pkg::cycle_state_e next_state;
  logic [sram_host_pkg::CNT_W-1:0] count;
  logic [sram_host_pkg::CNT_W-1:0] next_count;
  logic is_write;
  logic next_is_write;
  logic latch_gate_n;
  logic next_latch_gate_n;
  logic level_select_n;
  logic next_level_select_n;
  logic latched_select_n;
  logic next_latched_select_n;
  logic write_enable_n;
  logic next_write_enable_n;
  logic dq_oe_n;
  logic next_dq_oe_n;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] next_wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic [DATA_W-1:0] dq_sync;

  // ****************************************************************
  // read data pins cross into the core clock
  // ****************************************************************
  pin_sync #(
    .WIDTH(DATA_W)
  ) u_dq_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_dq),
    .o_pin(dq_sync)
  );

  // ****************************************************************
  // cycle sequencer
  // ****************************************************************
  // strobe, level select and write enable always move on the same edge, so
  // level select never leads write enable and the device output never fights o_dq
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_is_write = is_write;
    next_latch_gate_n = latch_gate_n;
    next_level_select_n = level_select_n;
    next_latched_select_n = latched_select_n;
    next_write_enable_n = write_enable_n;
    next_dq_oe_n = dq_oe_n;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    unique case (state)
      sram_host_pkg::ST_IDLE:
      begin
        if (i_req)
        begin
          // present address and data while strobe is still high
          next_addr = i_addr;
          next_wdata = i_wdata;
          next_is_write = i_write;
          next_dq_oe_n = ~i_write;
          next_latched_select_n = 1'b0;
          next_count = SETUP_CNT;
          next_state = sram_host_pkg::ST_SETUP;
        end
      end
      sram_host_pkg::ST_SETUP:
      begin
        if (count == CNT_ZERO)
        begin
          // strobe falls with level select and write enable together
          next_latch_gate_n = 1'b0;
          next_level_select_n = 1'b0;
          next_write_enable_n = ~is_write;
          next_count = is_write ? WRITE_CNT : READ_CNT;
          next_state = sram_host_pkg::ST_ACTIVE;
        end
        else
        begin
          next_count = count - CNT_ONE;
        end
      end
      sram_host_pkg::ST_ACTIVE:
      begin
        if (count == CNT_ZERO)
        begin
          // all write controls rise on one edge, ending the write
          next_latch_gate_n = 1'b1;
          next_level_select_n = 1'b1;
          next_latched_select_n = 1'b1;
          // each write gets its own full strobe cycle; keeping write enable low is not used
          next_write_enable_n = 1'b1;
          if (!is_write)
          begin
            next_rdata = dq_sync;
            next_rvalid = 1'b1;
          end
          next_count = HOLD_CNT;
          next_state = sram_host_pkg::ST_HOLD;
        end
        else
        begin
          next_count = count - CNT_ONE;
        end
      end
      sram_host_pkg::ST_HOLD:
      begin
        // data and address stay put after the rising controls
        if (count == CNT_ZERO)
        begin
          next_dq_oe_n = 1'b1;
          next_count = PRE_CNT;
          next_state = sram_host_pkg::ST_PRECHARGE;
        end
        else
        begin
          next_count = count - CNT_ONE;
        end
      end
      sram_host_pkg::ST_PRECHARGE:
      begin
        // hold time already counts toward the strobe high time
        if (count <= HOLD_CNT + CNT_ONE)
        begin
          next_state = sram_host_pkg::ST_IDLE;
        end
        else
        begin
          next_count = count - CNT_ONE;
        end
      end
      default:
      begin
        next_state = sram_host_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer registers; reset leaves the memory deselected and the bus free
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= sram_host_pkg::ST_IDLE;
      count <= '0;
      is_write <= 1'b0;
      latch_gate_n <= 1'b1;
      level_select_n <= 1'b1;
      latched_select_n <= 1'b1;
      write_enable_n <= 1'b1;
      dq_oe_n <= 1'b1;
      addr <= '0;
      wdata <= '0;
      rdata <= '0;
      rvalid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      is_write <= next_is_write;
      latch_gate_n <= next_latch_gate_n;
      level_select_n <= next_level_select_n;
      latched_select_n <= next_latched_select_n;
      write_enable_n <= next_write_enable_n;
      dq_oe_n <= next_dq_oe_n;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // latched select from its own flop: a gate of several registers could glitch high
  // on the very edge where the strobe falls and be captured by the memory
  assign o_latched_select_n = latched_select_n;
  assign o_ready = (state == sram_host_pkg::ST_IDLE);
  assign o_rdata = rdata;
  assign o_rvalid = rvalid;
  assign o_latch_gate_n = latch_gate_n;
  assign o_level_select_n = level_select_n;
  assign o_write_enable_n = write_enable_n;
  assign o_addr = addr;
  assign o_dq = wdata;
  assign o_dq_oe_n = dq_oe_n;

endmodule // sram_host_ctrl

/* hdl/sram_host_pkg.sv */
package sram_host_pkg;

  // ****************************************************************
  // clock and pin timing, times in ns as printed, worst grade taken
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_ADDR_SETUP_NS = 25;
  localparam int T_ADDR_HOLD_NS = 25;
  localparam int T_STROBE_LOW_NS = 150;
  localparam int T_STROBE_HIGH_NS = 140;
  localparam int T_ACCESS_NS = 275;
  localparam int T_OUTPUT_ENABLE_DELAY_NS = 150;
  localparam int T_MIN_WRITE_PULSE_NS = 150;
  localparam int T_WRITE_DATA_SETUP_NS = 150;
  localparam int T_WRITE_DATA_HOLD_NS = 60;
  localparam int SYNC_STAGES = 2;

  // least times round up to whole cycles
  function automatic int cycles_up(input int ns);
    cycles_up = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  function automatic int max2(input int a, input int b);
    max2 = (a > b) ? a : b;
  endfunction

  // ****************************************************************
  // derived cycle counts
  // ****************************************************************
  localparam int CNT_W = 6;
  localparam int ADDR_SETUP_CYC = cycles_up(T_ADDR_SETUP_NS);
  localparam int DATA_HOLD_CYC = max2(cycles_up(T_WRITE_DATA_HOLD_NS),
                                      cycles_up(T_ADDR_HOLD_NS));
  localparam int PRECHARGE_CYC = cycles_up(T_STROBE_HIGH_NS);
  // read low time covers access, the output enable delay and the pin synchroniser
  localparam int READ_LOW_CYC = max2(cycles_up(T_STROBE_LOW_NS),
    max2(cycles_up(T_ACCESS_NS), cycles_up(T_OUTPUT_ENABLE_DELAY_NS)) + SYNC_STAGES + 1);
  localparam int WRITE_LOW_CYC = max2(cycles_up(T_STROBE_LOW_NS),
    max2(cycles_up(T_MIN_WRITE_PULSE_NS), cycles_up(T_WRITE_DATA_SETUP_NS)));

  // ****************************************************************
  // organisations
  // ****************************************************************
  localparam int WIDE_ADDR_W = 8;
  localparam int WIDE_DATA_W = 4;
  localparam int NARROW_ADDR_W = 10;
  localparam int NARROW_DATA_W = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_ACTIVE = 3'h2,
    ST_HOLD = 3'h3,
    ST_PRECHARGE = 3'h4
  } cycle_state_e;

endpackage

/* hdl/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // pins in and synchronised copy out
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_pin
);

  logic [WIDTH-1:0] first_stage;
  logic [WIDTH-1:0] second_stage;

  // ****************************************************************
  // two flops per bit; the first stage feeds only the second
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge i_core_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          first_stage[g] <= 1'b0;
          second_stage[g] <= 1'b0;
        end
        else
        begin
          first_stage[g] <= i_pin[g];
          second_stage[g] <= first_stage[g];
        end
      end
    end
  endgenerate

  assign o_pin = second_stage;

endmodule // pin_sync

/* verif/sram_host_ctrl_sva.sv */
`timescale 1ns/100ps
module sram_host_ctrl_sva #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 4
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // pins watched
  input wire logic o_rvalid,
  input wire logic o_latch_gate_n,
  input wire logic o_latched_select_n,
  input wire logic o_level_select_n,
  input wire logic o_write_enable_n,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic [DATA_W-1:0] o_dq,
  input wire logic o_dq_oe_n
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] low_cnt;
  logic [7:0] high_cnt;
  logic [7:0] next_low_cnt;
  logic [7:0] next_high_cnt;
  // phase counters saturate so a long idle never wraps into a short one
  always_comb
  begin
    next_low_cnt = o_latch_gate_n ? 8'h00 : low_cnt + {7'h00, ~&low_cnt};
    next_high_cnt = o_latch_gate_n ? high_cnt + {7'h00, ~&high_cnt} : 8'h00;
  end
  // reset counts as a long high phase
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      low_cnt <= 8'h00;
      high_cnt <= 8'hff;
    end
    else
    begin
      low_cnt <= next_low_cnt;
      high_cnt <= next_high_cnt;
    end
  end
  // ********
  // pin timing
  // ********
  sequence s_addr_held;
    $stable(o_addr)[*3];
  endsequence
  sequence s_data_held;
    (!o_dq_oe_n && $stable(o_dq))[*6];
  endsequence
  property p_read_long;
    $rose(o_latch_gate_n) && $past(o_write_enable_n) |-> low_cnt >= 8'h1c;
  endproperty
  property p_addr_setup;
    $fell(o_latch_gate_n) |-> o_addr == $past(o_addr, 3) && $past(o_latched_select_n, 3) == 1'b0;
  endproperty
  a_strobe_low_min: assert property ($rose(o_latch_gate_n) |-> low_cnt >= 8'h0f)
    else $error("strobe low too short");
  a_strobe_high_min: assert property ($fell(o_latch_gate_n) |-> high_cnt >= 8'h0e)
    else $error("strobe high too short");
  a_read_low_long: assert property (p_read_long)
    else $error("read strobe shorter than access");
  a_rvalid_at_rise: assert property (o_rvalid == ($rose(o_latch_gate_n) && $past(o_write_enable_n)))
    else $error("read data taken at wrong time");
  a_addr_setup: assert property (p_addr_setup)
    else $error("address or select not set up");
  a_addr_hold: assert property (!o_latch_gate_n |=> s_addr_held)
    else $error("address not held");
  a_write_joint: assert property (!o_write_enable_n |-> !o_latch_gate_n && !o_level_select_n)
    else $error("write enable outside strobe");
  a_write_data: assert property (!o_write_enable_n |-> !o_dq_oe_n && $stable(o_dq))
    else $error("write data moved");
  a_write_hold: assert property ($rose(o_write_enable_n) |-> s_data_held)
    else $error("write data not held");
  a_no_contention: assert property (!o_dq_oe_n |-> o_level_select_n || !o_write_enable_n)
    else $error("bus contention");
endmodule // sram_host_ctrl_sva
bind sram_host_ctrl sram_host_ctrl_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) sram_host_ctrl_sva_inst (.*);

/* verif/sram_dev_model.sv */
`timescale 1ns/100ps
module sram_dev_model (
  // control pins from the host
  input wire logic i_latch_gate_n,
  input wire logic i_latched_select_n,
  input wire logic i_level_select_n,
  input wire logic i_write_enable_n,
  // address and shared data
  input wire logic [7:0] i_addr,
  input wire logic [3:0] i_din,
  output logic [3:0] o_dout
);
  logic [3:0] mem [0:255];
  logic [7:0] a_lat;
  logic sel_m;
  logic sel_s;
  logic fetched = 1'b0;
  logic [3:0] q_lat;
  logic drive;
  // ********
  // latches
  // ********
  always @* if (i_latch_gate_n) a_lat = i_addr;
  always @* if (i_latch_gate_n) sel_m = i_latched_select_n;
  // slave rank moves only while strobe low, so a rising strobe changes nothing
  always @* if (!i_latch_gate_n) sel_s = sel_m;
  // data are not ready until a full access time after the fall
  always @(negedge i_latch_gate_n)
  begin
    fetched = 1'b0;
    fetched <= #(sram_host_pkg::T_ACCESS_NS) 1'b1;
  end
  always @* if (!i_latch_gate_n) q_lat = fetched ? mem[a_lat] : ~mem[a_lat];
  // write only while all four controls are low
  always @* if (!i_latch_gate_n && !sel_s && !i_level_select_n && !i_write_enable_n)
    mem[a_lat] = i_din;
  // a released bus shows the inverse rather than the last value
  assign drive = !sel_s && !i_level_select_n && i_write_enable_n;
  assign o_dout = drive ? q_lat : ~q_lat;
endmodule // sram_dev_model

/* verif/strobed_static_ram_core_test.sv */
`timescale 1ns/100ps
module strobed_static_ram_core_test;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_req = 1'b0;
  logic i_write = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [3:0] i_wdata = 4'h0;
  logic [3:0] i_dq, o_dq, o_rdata, dev_q;
  logic [7:0] o_addr;
  logic o_ready, o_rvalid, o_latch_gate_n, o_latched_select_n;
  logic o_level_select_n, o_write_enable_n, o_dq_oe_n;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  always #5 i_core_clk = ~i_core_clk;
  // host wins the shared pins only while its enable is low
  assign i_dq = o_dq_oe_n ? dev_q : o_dq;
  sram_host_ctrl #(.WIDE_ORG(1'b1)) sram_host_ctrl_inst (.i_core_clk(i_core_clk),
    .i_rst(i_rst), .i_req(i_req), .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_ready(o_ready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_latch_gate_n(o_latch_gate_n), .o_latched_select_n(o_latched_select_n),
    .o_level_select_n(o_level_select_n), .o_write_enable_n(o_write_enable_n),
    .o_addr(o_addr), .i_dq(i_dq), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n));
  sram_dev_model sram_dev_model_inst (.i_latch_gate_n(o_latch_gate_n),
    .i_latched_select_n(o_latched_select_n), .i_level_select_n(o_level_select_n),
    .i_write_enable_n(o_write_enable_n), .i_addr(o_addr), .i_din(i_dq), .o_dout(dev_q));
  // ********
  // shared tasks
  // ********
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait, returning 1 ns after an edge
  task automatic wait_hi(ref logic s);
    for (int n = 0; n < 99 && s !== 1'b1; n++)
    begin
      @(posedge i_core_clk);
      #1;
    end
  endtask
  task automatic op(input logic wr, input logic [7:0] a, input logic [3:0] d);
    wait_hi(o_ready);
    i_write = wr;
    i_addr = a;
    i_wdata = d;
    i_req = 1'b1;
    @(posedge i_core_clk);
    #1;
    i_req = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] d);
    op(1'b0, a, 4'h0);
    wait_hi(o_rvalid);
    check("rvalid", 4'h1, {3'h0, o_rvalid});
    check("read data", d, o_rdata);
  endtask
  // ********
  // scenarios
  // ********
  task automatic test_idle;
    check("idle pins", 4'hf, {o_latch_gate_n, o_level_select_n, o_write_enable_n, o_dq_oe_n});
    check("ready", 4'h1, {3'h0, o_ready});
  endtask
  // corner addresses back to back, read back in reverse order
  task automatic test_corners;
    logic [7:0] a [4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};
    for (int k = 0; k < 4; k++) op(1'b1, a[k], a[k][3:0] ^ 4'h9);
    for (int k = 3; k >= 0; k--) rd(a[k], a[k][3:0] ^ 4'h9);
  endtask
  // a request while busy must leave no trace
  task automatic test_refused;
    op(1'b1, 8'h33, 4'h3);
    @(posedge i_core_clk);
    #1;
    i_wdata = 4'hc;
    i_req = 1'b1;
    repeat (20) @(posedge i_core_clk);
    #1;
    i_req = 1'b0;
    rd(8'h33, 4'h3);
  endtask
  // reset in setup drops the pins before any write begins
  task automatic test_mid_reset;
    op(1'b1, 8'h5a, 4'h0);
    i_rst = 1'b1;
    @(posedge i_core_clk);
    #1;
    test_idle();
    i_rst = 1'b0;
    rd(8'h5a, 4'h3);
  endtask
  task automatic final_report;
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // a hang is cut short well beyond the expected run
  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      errors++;
      final_report();
    end
  end
  initial
  begin
    repeat (3) @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    test_idle();
    test_corners();
    test_refused();
    test_mid_reset();
    final_report();
  end
endmodule // strobed_static_ram_core_test
